// *** design/lips_defs.svh ***
// Constants for the latch input pin select block: offsets, fields, codes
`ifndef LIPS_DEFS_SVH
`define LIPS_DEFS_SVH

// ==================================================
// Register bus geometry
`define LIPS_ADDR_W 4
`define LIPS_DATA_W 16

// ==================================================
// Register offsets (word index on the plain port)
`define LIPS_OFS_SELECT 4'h0
`define LIPS_OFS_ACTIVE 4'h1
`define LIPS_OFS_STATUS 4'h2

// ==================================================
// Field layout of the select word
`define LIPS_CODE_LSB 0
`define LIPS_CODE_MSB 11
`define LIPS_POL_LSB 12
`define LIPS_POL_MSB 15

// ==================================================
// Reset value of the select word (closed-contact, pin 7)
`define LIPS_SELECT_RST 16'h1007

// ==================================================
// Pin allocation codes that route a connector pin
`define LIPS_CODE_PIN6 12'h006
`define LIPS_CODE_PIN7 12'h007
`define LIPS_CODE_PIN8 12'h008
`define LIPS_CODE_PIN12 12'h012
`define LIPS_CODE_PIN13 12'h013
`define LIPS_CODE_PIN14 12'h014

// ==================================================
// Polarity codes
`define LIPS_POL_OFF 4'h0
`define LIPS_POL_CLOSED 4'h1
`define LIPS_POL_OPEN 4'h2

// ==================================================
// Connector input count and status bit positions
`define LIPS_PIN_N 15
`define LIPS_STAT_LATCH 0
`define LIPS_STAT_LEVEL 1
`define LIPS_STAT_ROUTED 2
`define LIPS_STAT_PENDING 3

`endif

// *** design/lips_pkg.sv ***
// Types shared by the latch input pin select block
package lips_pkg;

  // ==================================================
  // Field types
  typedef logic [11:0] lips_code_t; // Pin allocation code, three hex digits
  typedef logic [3:0] lips_pol_t; // Polarity selection digit
  typedef logic [14:0] lips_pins_t; // Synchronised connector levels

  // Packed select word: polarity on top, code below
  typedef struct packed {
    lips_pol_t pol;
    lips_code_t code;
  } lips_sel_t;

endpackage : lips_pkg

// *** design/lips_cfg_if.sv ***
// Carrier between the top and the pin decoder: setting, pins, result
`timescale 1ns/1ns
interface lips_cfg_if;
  lips_pkg::lips_sel_t cfg; // Setting now in force
  lips_pkg::lips_pins_t pins; // Synchronised pin levels
  logic routed; // Code names a real pin
  logic level; // Level of the chosen pin
  logic active; // Polarity-adjusted latch input

  // Top side drives setting and pins
  modport src (output cfg, output pins, input routed, input level, input active);
  // Decoder side computes the result
  modport dec (input cfg, input pins, output routed, output level, output active);
endinterface : lips_cfg_if

// *** design/lips_pin_sync.sv ***
// Two-stage synchroniser for every connector input pin
`timescale 1ns/1ns
`include "lips_defs.svh"
module lips_pin_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Raw and synchronised levels
  input wire logic [`LIPS_PIN_N-1:0] pin_raw,
  output logic [`LIPS_PIN_N-1:0] pin_sync
);

  // First stage, read only by the second
  logic [`LIPS_PIN_N-1:0] meta_reg;

  // ==================================================
  // One synchroniser per pin
  genvar i;
  generate
    for (i = 0; i < `LIPS_PIN_N; i = i + 1)
    begin : g_sync
      // Open contacts read low until the chain fills
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          meta_reg[i] <= 1'b0;
          pin_sync[i] <= 1'b0;
        end
        else
        begin
          meta_reg[i] <= pin_raw[i];
          pin_sync[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule : lips_pin_sync

// *** design/lips_pin_decode.sv ***
// Pin selection and polarity for the latch input, purely combinational
`timescale 1ns/1ns
`include "lips_defs.svh"
module lips_pin_decode
(
  // Setting and pins in, result out
  lips_cfg_if.dec cfg_bus
);

  // ==================================================
  // Pin routing from the allocation code
  always_comb
  begin
    cfg_bus.routed = 1'b1;
    cfg_bus.level = 1'b0;
    case (cfg_bus.cfg.code)
      `LIPS_CODE_PIN6: cfg_bus.level = cfg_bus.pins[6];
      `LIPS_CODE_PIN7: cfg_bus.level = cfg_bus.pins[7];
      `LIPS_CODE_PIN8: cfg_bus.level = cfg_bus.pins[8];
      `LIPS_CODE_PIN12: cfg_bus.level = cfg_bus.pins[12];
      `LIPS_CODE_PIN13: cfg_bus.level = cfg_bus.pins[13];
      `LIPS_CODE_PIN14: cfg_bus.level = cfg_bus.pins[14];
      // Every other code leaves the input dead
      default: cfg_bus.routed = 1'b0;
    endcase
  end

  // ==================================================
  // Polarity; unknown digits are treated as off for safety
  always_comb
  begin
    case (cfg_bus.cfg.pol)
      `LIPS_POL_CLOSED: cfg_bus.active = cfg_bus.routed & cfg_bus.level;
      `LIPS_POL_OPEN: cfg_bus.active = cfg_bus.routed & ~cfg_bus.level;
      default: cfg_bus.active = 1'b0;
    endcase
  end

endmodule : lips_pin_decode

// *** design/lips_latch_select.sv ***
// Top of the latch input pin select block: registers, restart, routing
`timescale 1ns/1ns
`include "lips_defs.svh"
module lips_latch_select
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [`LIPS_ADDR_W-1:0] reg_addr,
  input wire logic [`LIPS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`LIPS_DATA_W-1:0] reg_rdata,
  // Restart request, same clock domain
  input wire logic restart,
  // Connector contacts, high means closed
  input wire logic [`LIPS_PIN_N-1:0] conn_pin,
  // Latch input toward the capture logic
  output logic latch_in,
  output logic cfg_pending
);

  // ==================================================
  // Storage
  lips_pkg::lips_sel_t select_reg; // Software written setting
  lips_pkg::lips_sel_t active_reg; // Setting in force since restart
  logic [`LIPS_DATA_W-1:0] rdata_next; // Read mux result
  logic [`LIPS_PIN_N-1:0] pin_sync; // Pins after two flops
  logic latch_next; // Decoder result
  logic pending_next; // Written and restarted settings differ

  // Carrier to the decoder
  lips_cfg_if cfg_bus ();

  // ==================================================
  // Pin synchroniser; contacts are asynchronous to clk
  lips_pin_sync u_sync
  (
    .clk (clk),
    .sys_rst (sys_rst),
    .pin_raw (conn_pin),
    .pin_sync (pin_sync)
  );

  // ==================================================
  // Decoder sees only the restarted setting
  assign cfg_bus.cfg = active_reg;
  assign cfg_bus.pins = pin_sync;

  lips_pin_decode u_decode
  (
    .cfg_bus (cfg_bus.dec)
  );

  assign latch_next = cfg_bus.active;
  assign pending_next = (select_reg != active_reg);

  // ==================================================
  // Software setting; writes land here and wait
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      select_reg <= `LIPS_SELECT_RST;
    end
    else if (reg_wr && (reg_addr == `LIPS_OFS_SELECT))
    begin
      select_reg <= reg_wdata;
    end
  end

  // ==================================================
  // Setting in force; copied only on restart
  // A write in the restart cycle is not taken: the old word is copied
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      active_reg <= `LIPS_SELECT_RST;
    end
    else if (restart)
    begin
      active_reg <= select_reg;
    end
  end

  // ==================================================
  // Latch input register; one flop after the decoder
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      latch_in <= 1'b0;
    end
    else
    begin
      latch_in <= latch_next;
    end
  end

  // ==================================================
  // Pending flag; tells software a restart is still owed
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_pending <= 1'b0;
    end
    else
    begin
      cfg_pending <= pending_next;
    end
  end

  // ==================================================
  // Read mux
  always_comb
  begin
    rdata_next = '0;
    case (reg_addr)
      // Written setting
      `LIPS_OFS_SELECT: rdata_next = select_reg;
      // Setting in force
      `LIPS_OFS_ACTIVE: rdata_next = active_reg;
      // Live state bits
      `LIPS_OFS_STATUS:
      begin
        rdata_next[`LIPS_STAT_LATCH] = latch_in;
        rdata_next[`LIPS_STAT_LEVEL] = cfg_bus.level;
        rdata_next[`LIPS_STAT_ROUTED] = cfg_bus.routed;
        rdata_next[`LIPS_STAT_PENDING] = cfg_pending;
      end
      // Unmapped reads return zero
      default: rdata_next = '0;
    endcase
  end

  // ==================================================
  // Read data, valid only the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata <= '0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_next;
    end
    else
    begin
      // Zero outside the answer cycle keeps the bus quiet
      reg_rdata <= '0;
    end
  end

  // ==================================================
  // Checks
  // Helper: independent view of which codes route a pin
  logic chk_routed;
  assign chk_routed = (active_reg.code == `LIPS_CODE_PIN6)
                   || (active_reg.code == `LIPS_CODE_PIN7)
                   || (active_reg.code == `LIPS_CODE_PIN8)
                   || (active_reg.code == `LIPS_CODE_PIN12)
                   || (active_reg.code == `LIPS_CODE_PIN13)
                   || (active_reg.code == `LIPS_CODE_PIN14);

  // Helper: pin number from the two low decimal digits of the code
  // Shifting past the top pin gives zero, so odd codes naming pins 15 to 31 read low
  logic [4:0] chk_pin_idx; // Pin number named by the code
  logic chk_level; // Level of that pin, worked out apart from the decoder
  logic chk_sel_level; // Level as the status word should show it
  assign chk_pin_idx = (5'(active_reg.code[7:4]) * 5'h0a) + 5'(active_reg.code[3:0]);
  assign chk_level = |(pin_sync & (15'h0001 << chk_pin_idx));
  assign chk_sel_level = chk_routed && chk_level;

  // Write of the select word
  sequence s_write_sel;
    reg_wr && (reg_addr == `LIPS_OFS_SELECT);
  endsequence

  // Restart pulse with no write beside it
  sequence s_restart;
    restart && !reg_wr;
  endsequence

  // Write, a quiet cycle, then restart puts the written word in force
  property p_write_then_apply;
    @(posedge clk) disable iff (sys_rst)
    s_write_sel ##1 !reg_wr ##1 s_restart |=> (active_reg == $past(reg_wdata, 3));
  endproperty

  // Pin 6 routed with closed polarity follows the pin
  a_pin6_route: assert property (
    @(posedge clk) disable iff (sys_rst)
    (active_reg.code == `LIPS_CODE_PIN6) && (active_reg.pol == `LIPS_POL_CLOSED)
      && $stable(active_reg)
      |=> (latch_in == $past(pin_sync[6])))
    else $error("latch input does not follow pin 6");

  // Pin 13 routed with open polarity inverts the pin
  a_pin13_route: assert property (
    @(posedge clk) disable iff (sys_rst)
    (active_reg.code == `LIPS_CODE_PIN13) && (active_reg.pol == `LIPS_POL_OPEN)
      |=> (latch_in == !$past(pin_sync[13])))
    else $error("latch input does not follow pin 13");

  // Dead codes keep the input low for the next cycle
  a_dead_code: assert property (
    @(posedge clk) disable iff (sys_rst)
    !chk_routed && $stable(active_reg) |=> !latch_in)
    else $error("latch input active with unrouted code");

  // Polarity off keeps the input low two cycles on
  a_pol_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    (active_reg.pol == `LIPS_POL_OFF) ##1 (active_reg.pol == `LIPS_POL_OFF)
      |=> !latch_in [*1])
    else $error("latch input active with polarity off");

  // Closed polarity: active exactly while the chosen pin is high
  a_pol_closed: assert property (
    @(posedge clk) disable iff (sys_rst)
    chk_routed && (active_reg.pol == `LIPS_POL_CLOSED)
      |=> (latch_in == $past(chk_level)))
    else $error("closed polarity not honoured");

  // Open polarity: active exactly while the chosen pin is low
  a_pol_open: assert property (
    @(posedge clk) disable iff (sys_rst)
    chk_routed && (active_reg.pol == `LIPS_POL_OPEN)
      |=> (latch_in == !$past(chk_level)))
    else $error("open polarity not honoured");

  // Undefined polarity digits keep the input low
  a_pol_spare: assert property (
    @(posedge clk) disable iff (sys_rst)
    (active_reg.pol > `LIPS_POL_OPEN) |=> !latch_in)
    else $error("latch input active with spare polarity");

  // Setting in force holds without a restart
  a_hold_cfg: assert property (
    @(posedge clk) disable iff (sys_rst)
    !restart |=> $stable(active_reg))
    else $error("setting changed without restart");

  // Written then restarted setting is in force
  a_apply_write: assert property (p_write_then_apply)
    else $error("restart did not apply written setting");

  // Pending flag rises two cycles after a differing write
  a_pending_flag: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_write_sel ##1 (select_reg != active_reg) |=> cfg_pending)
    else $error("pending flag missing after write");

  // Restart without a write clears the pending flag two edges on
  a_restart_settle: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_restart |-> ##2 !cfg_pending)
    else $error("pending flag still set after restart");

  // ==================================================
  // Register port checks
  // Read of the select word answers next cycle
  a_read_select: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_rd && (reg_addr == `LIPS_OFS_SELECT) |=> (reg_rdata == $past(select_reg)))
    else $error("select readback wrong");

  // Read of the setting in force answers next cycle
  a_read_active: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_rd && (reg_addr == `LIPS_OFS_ACTIVE) |=> (reg_rdata == $past(active_reg)))
    else $error("active readback wrong");

  // Status read shows routing and the chosen pin level
  a_read_status: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_rd && (reg_addr == `LIPS_OFS_STATUS)
      |=> (reg_rdata[`LIPS_STAT_ROUTED] == $past(chk_routed))
      && (reg_rdata[`LIPS_STAT_LEVEL] == $past(chk_sel_level)))
    else $error("status readback wrong");

  // Read data fall back to zero outside the answer cycle
  a_rdata_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    !reg_rd |=> (reg_rdata == 16'h0000))
    else $error("read data not zero when idle");

  // Select write lands on the next edge, restart or not
  a_write_select: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_write_sel |=> (select_reg == $past(reg_wdata)))
    else $error("select write lost");

endmodule : lips_latch_select

// *** test/lips_contacts.sv ***
// Model of the switch and sensor contacts wired to the connector inputs
`timescale 1ns/1ns
`include "lips_defs.svh"
module lips_contacts
(
  // Clock
  input wire logic clk,
  // Contact pattern wanted by the bench, high means closed
  input wire logic [`LIPS_PIN_N-1:0] want_pins,
  // Connector levels seen by the block
  output logic [`LIPS_PIN_N-1:0] conn_pin
);
  // ==================================================
  // Contacts
  // All open at power-up so no pin starts unknown
  initial conn_pin = 15'h0000;
  // Contacts settle just after an edge
  always @(posedge clk)
  begin
    conn_pin <= #1 want_pins;
  end
endmodule : lips_contacts

// *** test/tb.sv ***
// Self-checking bench for the latch input pin select block
`timescale 1ns/1ns
`include "lips_defs.svh"
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb;
  // ==================================================
  // Signals
  logic clk = 1'b0; // 250 MHz clock
  logic sys_rst = 1'b1; // Reset, held at start
  logic [3:0] reg_addr = 4'h0; // Register index
  logic [15:0] reg_wdata = 16'h0000; // Write data
  logic reg_wr = 1'b0; // Write strobe
  logic reg_rd = 1'b0; // Read strobe
  logic [15:0] reg_rdata; // Read data
  logic restart = 1'b0; // Restart pulse
  logic [14:0] want_pins = 15'h0000; // Contact pattern
  logic [14:0] conn_pin; // Connector levels
  logic latch_in; // Latch input result
  logic cfg_pending; // Setting waits for restart
  int mismatches = 0; // Failed comparisons
  int num_checks = 0; // All comparisons
  logic [15:0] rd; // Last read word
  // Codes 000-009 and 010-015 in hex digits
  logic [11:0] codes [16] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h005,
    12'h006, 12'h007, 12'h008, 12'h009, 12'h010, 12'h011, 12'h012, 12'h013, 12'h014, 12'h015};

  // ==================================================
  // Clock and instances
  initial forever #2 clk = ~clk;
  lips_contacts i_lips_contacts (.clk(clk), .want_pins(want_pins), .conn_pin(conn_pin));
  lips_latch_select i_lips_latch_select (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .restart(restart), .conn_pin(conn_pin), .latch_in(latch_in), .cfg_pending(cfg_pending));

  // ==================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // One-cycle write strobe
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // Data stand only in the cycle after the strobe, so sample there
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  // Restart pulse, optionally beside a select write in the same cycle
  task automatic do_restart(input logic with_wr, input logic [15:0] d);
    @(posedge clk);
    restart <= 1'b1;
    reg_wr <= with_wr;
    reg_addr <= `LIPS_OFS_SELECT;
    reg_wdata <= d;
    @(posedge clk);
    restart <= 1'b0;
    reg_wr <= 1'b0;
  endtask : do_restart
  // Route one code and polarity, then drive the chosen pin both ways
  task automatic check_route(input logic [11:0] code, input logic [3:0] pol);
    logic routed;
    int p;
    logic exp_l;
    routed = (code >= 12'h006 && code <= 12'h008) || (code >= 12'h012 && code <= 12'h014);
    p = (code < 12'h010) ? int'(code) : int'(code) - 6;
    reg_write(`LIPS_OFS_SELECT, {pol, code});
    do_restart(1'b0, 16'h0000);
    reg_read(`LIPS_OFS_ACTIVE, rd);
    `CHK("active", {pol, code}, rd)
    for (int lvl = 0; lvl < 2; lvl++)
    begin
      // Chosen pin differs from all others so a wrong pick shows
      if (routed)
        want_pins <= lvl ? (15'h0001 << p) : ~(15'h0001 << p);
      else
        want_pins <= lvl ? 15'h7fff : 15'h0000;
      tick(6);
      exp_l = routed && ((pol == 4'h1 && lvl == 1) || (pol == 4'h2 && lvl == 0));
      `CHK("latch_in", exp_l, latch_in)
      reg_read(`LIPS_OFS_STATUS, rd);
      `CHK("status", {12'h000, 1'b0, routed, routed && lvl == 1, exp_l}, rd)
    end
  endtask : check_route
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // ==================================================
  // Watchdog against a hung run
  initial
  begin
    #200000;
    mismatches++;
    complete_run();
  end

  // ==================================================
  // Main sequence
  initial
  begin
    tick(6);
    sys_rst <= 1'b0;
    // Reset values and access kinds
    reg_read(`LIPS_OFS_SELECT, rd);
    `CHK("select rst", `LIPS_SELECT_RST, rd)
    #4;
    `CHK("rdata idle", 16'h0000, reg_rdata)
    reg_write(`LIPS_OFS_ACTIVE, 16'h2012);
    reg_write(4'hf, 16'h2012);
    reg_read(`LIPS_OFS_ACTIVE, rd);
    `CHK("active ro", `LIPS_SELECT_RST, rd)
    reg_read(4'hf, rd);
    `CHK("unmapped", 16'h0000, rd)
    // Codes 000-009 and 010-015, polarity digits 0 to 3
    for (int c = 0; c < 16; c++)
      for (int pl = 0; pl < 4; pl++)
        check_route(codes[c], pl[3:0]);
    // New setting waits for restart: pin 7 closed, old routing stays
    reg_write(`LIPS_OFS_SELECT, 16'h1007);
    do_restart(1'b0, 16'h0000);
    want_pins <= 15'h0080;
    reg_write(`LIPS_OFS_SELECT, 16'h1013);
    tick(6);
    `CHK("old route", 1'b1, latch_in)
    `CHK("pending", 1'b1, cfg_pending)
    reg_read(`LIPS_OFS_ACTIVE, rd);
    `CHK("active old", 16'h1007, rd)
    // Write beside restart applies the word written before
    do_restart(1'b1, 16'h1008);
    tick(3);
    `CHK("old word", 1'b0, latch_in)
    reg_read(`LIPS_OFS_ACTIVE, rd);
    `CHK("active mid", 16'h1013, rd)
    `CHK("still pend", 1'b1, cfg_pending)
    do_restart(1'b0, 16'h0000);
    want_pins <= 15'h0100;
    tick(6);
    `CHK("new route", 1'b1, latch_in)
    `CHK("pend clear", 1'b0, cfg_pending)
    complete_run();
  end
endmodule : tb
